// ### rtl/mis_pkg.sv
package mis_pkg;

   // ---------------------------------------------------------------
   // Register offsets and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MIS_ADDR_PENDING = 8'h09;
   localparam logic [7:0] MIS_ADDR_FEATURES = 8'h0D;
   localparam logic [7:0] MIS_RST_PENDING = 8'h00;
   localparam logic [7:0] MIS_RST_FEATURES = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MIS_BIT_WAKE = 2;
   localparam int MIS_BIT_SAMPLE = 3;
   localparam int MIS_BIT_EMPTY = 4;
   localparam int MIS_BIT_FULL = 5;
   localparam int MIS_BIT_LEVEL = 6;
   localparam int MIS_BIT_ACTIVITY = 7;
   localparam int MIS_BIT_HOLD = 3;
   localparam int MIS_BIT_REARM = 4;
   localparam int MIS_BIT_THREE_WIRE = 5;
   localparam int MIS_BIT_I2C_SEL = 6;
   localparam int MIS_BIT_SPI_SEL = 7;
   localparam logic [7:0] MIS_FEATURE_WMASK = 8'hF8;
   localparam logic [7:0] MIS_PENDING_MASK = 8'hFC;

   // ---------------------------------------------------------------
   // Queue size and operating modes
   // ---------------------------------------------------------------
   localparam int MIS_QUEUE_DEPTH = 32;
   localparam int MIS_SYNC_STAGES = 3;

   typedef enum logic [2:0] {
      MIS_MODE_SLEEP = 3'h0,
      MIS_MODE_STANDBY = 3'h1,
      MIS_MODE_WATCH = 3'h2,
      MIS_MODE_CONT = 3'h5,
      MIS_MODE_WATCH_SAMPLE = 3'h6,
      MIS_MODE_COUNTED = 3'h7
   } mis_mode_type;

   typedef enum logic [1:0] {
      MIS_IF_POWERUP,
      MIS_IF_I2C,
      MIS_IF_SPI4,
      MIS_IF_SPI3
   } mis_iface_type;

   // Register access from the serial engines
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic from_spi;
   } mis_access_type;

   // Events from the sampling pipeline and queue
   typedef struct packed {
      logic wake_transition;
      logic sample_done;
      logic queue_empty;
      logic queue_full;
      logic [5:0] queue_count;
      logic detector_fire;
   } mis_event_type;

endpackage

// ### rtl/mis_edge_flag.sv
`timescale 1ns/10ps
// Sticky flag set by a rising condition, or by the level in level mode; set beats clear.
module mis_edge_flag (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Condition and control
   input wire logic cond,
   input wire logic enable,
   input wire logic clear,
   input wire logic level_mode,
   // Flag
   output logic flag
);
   logic cond_q;
   wire rise = cond & ~cond_q;
   wire counted_capture_mode = level_mode ? cond : rise;
   wire set_now = counted_capture_mode & enable;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cond_q <= 1'b0;
         flag <= 1'b0;
      end else begin
         cond_q <= cond;
         flag <= set_now | (flag & ~clear);
      end
   end
endmodule // mis_edge_flag

// ### rtl/mis_irq_status.sv
`timescale 1ns/10ps
module mis_irq_status
   import mis_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register access from the serial engines
   input wire mis_access_type reg_access,
   output logic [7:0] reg_rdata,
   // Configuration held elsewhere
   input wire logic [7:0] irq_enable,
   input wire logic clear_by_write_select,
   input wire logic [4:0] queue_threshold,
   input wire logic queue_stream_mode,
   input wire logic powerup_is_spi,
   // Device state and events
   input wire mis_mode_type device_mode,
   input wire mis_event_type events,
   input wire logic serial_out_addr_pin_in,
   // Outputs to the rest of the device
   output logic [7:0] interrupt_pending_flags,
   output logic [7:0] interface_and_detector_features,
   output logic any_flag_pending,
   output logic results_update_enable,
   output logic queue_capture_enable,
   output logic detector_armed,
   output logic spi_accept,
   output logic i2c_accept,
   output logic three_wire_select,
   output mis_iface_type active_interface,
   output logic serial_out_addr_pin_oe,
   output logic serial_out_addr_pin_rx
);

   // ---------------------------------------------------------------
   // Pin synchroniser for the bidirectional data pin
   // ---------------------------------------------------------------
   logic [MIS_SYNC_STAGES-1:0] pin_sync;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_sync <= '0;
         serial_out_addr_pin_rx <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[MIS_SYNC_STAGES-2:0], serial_out_addr_pin_in};
         // Change counts once stages two and three agree
         if (pin_sync[1] == pin_sync[2]) begin
            serial_out_addr_pin_rx <= pin_sync[2];
         end
      end
   end

   // ---------------------------------------------------------------
   // Feature register decode
   // ---------------------------------------------------------------
   wire i2c_sel = interface_and_detector_features[MIS_BIT_I2C_SEL];
   wire spi_sel = interface_and_detector_features[MIS_BIT_SPI_SEL];
   wire three_sel = interface_and_detector_features[MIS_BIT_THREE_WIRE];
   wire rearm_on_clear = interface_and_detector_features[MIS_BIT_REARM];
   wire capture_hold = interface_and_detector_features[MIS_BIT_HOLD];
   wire none_sel = ~(i2c_sel | spi_sel | three_sel);

   // Host is trusted to keep one select bit set; with I2C and SPI both set neither is accepted
   assign spi_accept = ~i2c_sel;
   assign i2c_accept = ~spi_sel & ~three_sel;
   assign three_wire_select = three_sel;
   assign results_update_enable = ~none_sel;

   wire mis_iface_type next_iface = spi_sel ? MIS_IF_SPI4 :
                                    three_sel ? MIS_IF_SPI3 :
                                    i2c_sel ? MIS_IF_I2C : MIS_IF_POWERUP;
   // Power-up choice stands while nothing is selected
   wire mis_iface_type powerup_iface = powerup_is_spi ? MIS_IF_SPI4 : MIS_IF_I2C;
   assign active_interface = (next_iface == MIS_IF_POWERUP) ?
                             powerup_iface : next_iface;
   wire on_spi = (active_interface == MIS_IF_SPI4) || (active_interface == MIS_IF_SPI3);

   // Output enable tied low, so the data pin is never driven here; engine owns data
   assign serial_out_addr_pin_oe = 1'b0;

   // ---------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------
   wire access_ok = reg_access.from_spi ? spi_accept : i2c_accept;
   wire hit_pending = reg_access.addr == MIS_ADDR_PENDING;
   wire hit_features = reg_access.addr == MIS_ADDR_FEATURES;
   wire rd_pending = access_ok & reg_access.rd & hit_pending;
   wire wr_pending = access_ok & reg_access.wr & hit_pending;
   wire wr_features = access_ok & reg_access.wr & hit_features;

   wire write_clears = on_spi | clear_by_write_select;
   // Clear-by-write ignores the data written
   wire host_clear = write_clears ? wr_pending : rd_pending;

   // Low three bits always stored as zero
   wire [7:0] next_features = reg_access.wdata & MIS_FEATURE_WMASK;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         interface_and_detector_features <= MIS_RST_FEATURES;
      end else if (wr_features) begin
         interface_and_detector_features <= next_features;
      end
   end

   // ---------------------------------------------------------------
   // Event conditions
   // ---------------------------------------------------------------
   wire sample_mode = (device_mode == MIS_MODE_CONT) ||
                      (device_mode == MIS_MODE_COUNTED);
   wire in_watch_sample = device_mode == MIS_MODE_WATCH_SAMPLE;
   wire level_reached = events.queue_count >= {1'b0, queue_threshold};

   // Wake transition is already a pulse from the mode sequencer
   wire wake_cond = events.wake_transition;
   wire sample_cond = events.sample_done & sample_mode;
   wire activity_cond = events.detector_fire & in_watch_sample & detector_armed;

   // ---------------------------------------------------------------
   // Sticky flags
   // ---------------------------------------------------------------
   logic [7:0] flag_vec;
   logic [7:0] cond_vec;
   logic [7:0] level_vec;

   assign cond_vec = {activity_cond, level_reached, events.queue_full,
                      events.queue_empty, sample_cond, wake_cond, 2'b00};
   // Level-triggered flags set again after clear; edge ones need a new edge
   assign level_vec = {1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 2'b00};

   genvar gi;
   generate
      for (gi = MIS_BIT_WAKE; gi <= MIS_BIT_ACTIVITY; gi++) begin : g_flag
         mis_edge_flag u_flag (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .cond(cond_vec[gi]),
            .enable(irq_enable[gi]),
            .clear(host_clear),
            .level_mode(level_vec[gi]),
            .flag(flag_vec[gi])
         );
      end
   endgenerate
   assign flag_vec[1:0] = 2'b00;

   assign interrupt_pending_flags = flag_vec & MIS_PENDING_MASK;
   assign any_flag_pending = |interrupt_pending_flags;

   // ---------------------------------------------------------------
   // Activity detector arming and capture hold
   // ---------------------------------------------------------------
   wire activity_clear = host_clear & interrupt_pending_flags[MIS_BIT_ACTIVITY];
   logic hold_active;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         detector_armed <= 1'b1;
         hold_active <= 1'b0;
      end else begin
         if (!in_watch_sample) begin
            detector_armed <= 1'b1;
         end else if (activity_cond) begin
            detector_armed <= 1'b0;
         end else if (activity_clear && rearm_on_clear) begin
            detector_armed <= 1'b1;
         end
         if (activity_cond && capture_hold) begin
            hold_active <= 1'b1;
         end else if (activity_clear || !capture_hold) begin
            hold_active <= 1'b0;
         end
      end
   end

   // Streaming keeps capturing when full; hold freezes it for inspection
   assign queue_capture_enable = ~hold_active &
                                 (queue_stream_mode | ~events.queue_full);

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (access_ok && reg_access.rd) begin
         reg_rdata <= hit_pending ? interrupt_pending_flags :
                      hit_features ? interface_and_detector_features : 8'h00;
      end
   end
endmodule // mis_irq_status

// ### testbench/mis_irq_props.sv
`timescale 1ns/10ps
// ----
// Status and feature checker
// ----
module mis_irq_props
   import mis_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Access and configuration
   input wire mis_access_type reg_access,
   input wire logic [7:0] irq_enable,
   input wire logic clear_by_write_select,
   input wire mis_mode_type device_mode,
   input wire mis_event_type events,
   // Observed outputs
   input wire logic [7:0] interrupt_pending_flags,
   input wire logic [7:0] interface_and_detector_features,
   input wire logic any_flag_pending,
   input wire logic results_update_enable,
   input wire logic queue_capture_enable,
   input wire logic detector_armed,
   input wire logic spi_accept,
   input wire logic i2c_accept,
   input wire mis_iface_type active_interface
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire logic [7:0] flg = interrupt_pending_flags;
   wire logic [7:0] fea = interface_and_detector_features;
   wire logic acc = reg_access.from_spi ? spi_accept : i2c_accept;
   wire logic hit = acc && reg_access.addr == MIS_ADDR_PENDING;
   wire logic rd_mode = active_interface == MIS_IF_I2C && !clear_by_write_select;
   a_set_needs_enable: assert property ((flg & ~$past(flg) & ~$past(irq_enable)) == 8'h00)
      else $error("flag set without enable");
   a_summary_or: assert property (any_flag_pending == |flg)
      else $error("summary differs from flags");
   a_read_clears: assert property (reg_access.rd && hit && rd_mode && !$rose(events.queue_empty)
      && !$rose(events.queue_full) |=> flg[5:4] == 2'b00)
      else $error("read did not clear");
   a_write_clears: assert property (reg_access.wr && hit && !rd_mode && !$rose(events.queue_empty)
      && !$rose(events.queue_full) |=> flg[5:4] == 2'b00)
      else $error("write did not clear");
   a_read_keeps: assert property (reg_access.rd && hit && !rd_mode
      |=> (flg & $past(flg)) == $past(flg))
      else $error("read cleared in write mode");
   a_results_gate: assert property (fea[7:5] == 3'h0 |-> !results_update_enable)
      else $error("results updated without select");
   a_i2c_blocks_spi: assert property (fea[MIS_BIT_I2C_SEL] |-> !spi_accept)
      else $error("spi accepted in i2c select");
   a_spi_blocks_i2c: assert property (fea[MIS_BIT_SPI_SEL] |-> !i2c_accept)
      else $error("i2c accepted in spi select");
   a_activity_cause: assert property ($rose(flg[7]) |-> $past(device_mode) == MIS_MODE_WATCH_SAMPLE
      && $past(events.detector_fire))
      else $error("activity flag without event");
   a_hold_stops: assert property ($rose(flg[7]) && fea[MIS_BIT_HOLD] |-> !queue_capture_enable)
      else $error("capture not held");
   a_no_rearm: assert property (!fea[MIS_BIT_REARM] && device_mode == MIS_MODE_WATCH_SAMPLE
      && !detector_armed |=> !detector_armed)
      else $error("detector rearmed early");
   c_read_clear: cover property (reg_access.rd && hit && rd_mode && flg != 8'h00);
   c_write_clear: cover property (reg_access.wr && hit && !rd_mode && flg != 8'h00);
   c_activity: cover property ($rose(flg[7]));
endmodule // mis_irq_props

bind mis_irq_status mis_irq_props mis_irq_props_inst (.clk_sys, .sys_rst, .reg_access,
   .irq_enable, .clear_by_write_select, .device_mode, .events, .interrupt_pending_flags,
   .interface_and_detector_features, .any_flag_pending, .results_update_enable,
   .queue_capture_enable, .detector_armed, .spi_accept, .i2c_accept, .active_interface);

// ### testbench/mis_host_model.sv
`timescale 1ns/10ps
// ----
// Host: one-cycle strobes from the falling edge
// ----
module mis_host_model
   import mis_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Register access
   output mis_access_type reg_access
);
   initial reg_access = '0;
   task automatic access(input logic rd, input logic wr, input logic [7:0] a,
         input logic [7:0] d, input logic spi);
      logic [7:0] dm;
      dm = (a == MIS_ADDR_FEATURES) ? (d & MIS_FEATURE_WMASK) : d;
      @(negedge clk_sys);
      reg_access = '{rd, wr, a, dm, spi};
      @(negedge clk_sys);
      // Released lines carry the inverse, not the last value
      reg_access = '{1'b0, 1'b0, ~a, ~dm, ~spi};
   endtask
endmodule // mis_host_model

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
   import mis_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] irq_enable = 8'h00;
   logic cws = 1'b0;
   logic [4:0] thr = 5'h1F;
   logic strm = 1'b1;
   logic pin = 1'b0;
   logic pin_rx;
   mis_mode_type mode = MIS_MODE_CONT;
   mis_event_type ev = '0;
   mis_access_type reg_access;
   mis_iface_type iface;
   logic [7:0] rdata, flags, feat;
   logic pend, res_en, cap_en, armed, spi_ok, i2c_ok, tw;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   initial forever #10 clk_sys = ~clk_sys;
   mis_host_model mis_host_model_inst (.clk_sys(clk_sys), .reg_access(reg_access));
   mis_irq_status mis_irq_status_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .reg_access(reg_access), .reg_rdata(rdata), .irq_enable(irq_enable),
      .clear_by_write_select(cws), .queue_threshold(thr), .queue_stream_mode(strm),
      .powerup_is_spi(1'b0), .device_mode(mode), .events(ev), .serial_out_addr_pin_in(pin),
      .interrupt_pending_flags(flags), .interface_and_detector_features(feat),
      .any_flag_pending(pend), .results_update_enable(res_en), .queue_capture_enable(cap_en),
      .detector_armed(armed), .spi_accept(spi_ok), .i2c_accept(i2c_ok), .three_wire_select(tw),
      .active_interface(iface), .serial_out_addr_pin_oe(), .serial_out_addr_pin_rx(pin_rx));
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 4000) begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
      mis_host_model_inst.access(1'b0, 1'b1, a, d, s);
   endtask
   task automatic rd(input logic [7:0] a, input logic s, input logic [7:0] e);
      mis_host_model_inst.access(1'b1, 1'b0, a, 8'h00, s);
      chk("rdata", e, rdata);
   endtask
   // Bits: 400 wake, 200 sample, 001 detector fire
   task automatic pulse(input mis_event_type m);
      ev = mis_event_type'(ev | m);
      tick();
      ev = mis_event_type'(ev & ~m);
      tick();
   endtask
   initial begin
      tick(12);
      sys_rst = 1'b0;
      rd(MIS_ADDR_FEATURES, 1'b0, MIS_RST_FEATURES);
      chk("results", 8'h00, {7'h00, res_en});
      chk("iface", {6'h00, MIS_IF_I2C}, {6'h00, iface});
      pulse(11'h200);
      chk("flags", 8'h00, flags);
      irq_enable = 8'hFF;
      pulse(11'h200);
      chk("flags", 8'h08, flags);
      chk("pend", 8'h01, {7'h00, pend});
      rd(MIS_ADDR_PENDING, 1'b0, 8'h08);
      chk("flags", 8'h00, flags);
      mode = MIS_MODE_STANDBY;
      pulse(11'h200);
      chk("flags", 8'h00, flags);
      pulse(11'h400);
      rd(MIS_ADDR_PENDING, 1'b0, 8'h04);
      ev.queue_empty = 1'b1;
      ev.queue_full = 1'b1;
      tick(2);
      rd(MIS_ADDR_PENDING, 1'b0, 8'h30);
      tick(2);
      chk("flags", 8'h00, flags);
      ev.queue_empty = 1'b0;
      ev.queue_full = 1'b0;
      tick();
      ev.queue_empty = 1'b1;
      ev.queue_full = 1'b1;
      tick(2);
      rd(MIS_ADDR_PENDING, 1'b0, 8'h30);
      thr = 5'h04;
      ev.queue_count = 6'h03;
      tick(2);
      chk("flags", 8'h00, flags);
      ev.queue_count = 6'h04;
      tick(2);
      ev.queue_count = 6'h00;
      rd(MIS_ADDR_PENDING, 1'b0, 8'h40);
      cws = 1'b1;
      mode = MIS_MODE_CONT;
      pulse(11'h200);
      rd(MIS_ADDR_PENDING, 1'b0, 8'h08);
      chk("flags", 8'h08, flags);
      wr(MIS_ADDR_PENDING, 8'h5A, 1'b0);
      chk("flags", 8'h00, flags);
      cws = 1'b0;
      wr(MIS_ADDR_FEATURES, 8'h58, 1'b0);
      rd(MIS_ADDR_FEATURES, 1'b0, 8'h58);
      chk("spi_ok", 8'h00, {7'h00, spi_ok});
      mode = MIS_MODE_WATCH_SAMPLE;
      pulse(11'h001);
      chk("flags", 8'h80, flags);
      chk("capture", 8'h00, {7'h00, cap_en});
      rd(MIS_ADDR_PENDING, 1'b0, 8'h80);
      pulse(11'h001);
      chk("flags", 8'h80, flags);
      wr(MIS_ADDR_FEATURES, 8'h48, 1'b0);
      rd(MIS_ADDR_PENDING, 1'b0, 8'h80);
      pulse(11'h001);
      chk("flags", 8'h00, flags);
      mode = MIS_MODE_CONT;
      tick(2);
      chk("armed", 8'h01, {7'h00, armed});
      wr(MIS_ADDR_FEATURES, 8'h80, 1'b0);
      chk("i2c_ok", 8'h00, {7'h00, i2c_ok});
      wr(MIS_ADDR_FEATURES, 8'h40, 1'b0);
      rd(MIS_ADDR_FEATURES, 1'b1, 8'h80);
      rd(8'h33, 1'b1, 8'h00);
      pulse(11'h400);
      rd(MIS_ADDR_PENDING, 1'b1, 8'h04);
      chk("flags", 8'h04, flags);
      wr(MIS_ADDR_PENDING, 8'h00, 1'b1);
      chk("flags", 8'h00, flags);
      chk("tw", 8'h00, {7'h00, tw});
      wr(MIS_ADDR_FEATURES, 8'h20, 1'b1);
      chk("tw", 8'h01, {7'h00, tw});
      chk("iface", {6'h00, MIS_IF_SPI3}, {6'h00, iface});
      chk("capture", 8'h01, {7'h00, cap_en});
      strm = 1'b0;
      tick();
      chk("capture", 8'h00, {7'h00, cap_en});
      pin = 1'b1;
      tick(2);
      chk("pin_rx", 8'h00, {7'h00, pin_rx});
      tick(3);
      chk("pin_rx", 8'h01, {7'h00, pin_rx});
      conclude();
   end
endmodule // testbench
